// File: core/psec_regs.v
// Purpose: Management slave for page select, event tallies and coding sublayer config.
// Assumes: mdc and mdioIn are synchronous to clk and mdc is well below clk/4.
// Notes:   Pages 2, 4, 5 and 6, page 0 above 16h and addresses below 13h go to the ext port.
// Notes on behaviour
// - Page field routes addresses 14h to 1Fh.
// - Reserved selector and tally bits read zero.
// - False carrier tally counts, clears on read.
// - False carrier tally sticks at FFh.
// - Receive error tally once per carrier.
// - No receive error count during collision.
// - Receive error tally saturates until read.
// - Free clock bit keeps receive clock running.
// - True quiet bit selects quiet transmit.
// - Force bit forces signal detection active.
// - Default option: link survives lock loss.
// - Modified option: link drops on lock loss.
// - Extend bit lengthens descrambler timeout.
`timescale 1ns/100ps
`default_nettype none
`include "psec_defs.vh"
module psec_regs #(
  parameter CNT_W     = 8,
  parameter TO_W      = 18,
  parameter SHORT_CYC = `PSEC_DESC_TO_SHORT_NS / `PSEC_CLK_PERIOD_NS,
  parameter LONG_CYC  = `PSEC_DESC_TO_LONG_NS / `PSEC_CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [4:0]  phyAddr,
  input  wire        mdc,
  input  wire        mdioIn,
  output reg         mdioOut,
  output reg         mdioOe,
  input  wire        falseCarrierEvent,
  input  wire        carrierValid,
  input  wire        invalidSymbol,
  input  wire        collision,
  input  wire        syncSeen,
  input  wire        signalLevelValid,
  output wire        rxClkFreeRun,
  output wire        trueQuietEn,
  output wire        signalDetectForce,
  output wire        descLocked,
  output wire        linkUp,
  output wire [2:0]  register_page_selector,
  output reg  [4:0]  extAddr,
  output reg         extRdEn,
  output reg         extWrEn,
  output reg  [15:0] extWrData,
  input  wire [15:0] extRdData
);
  localparam S_PRE  = 3'h0;
  localparam S_ST   = 3'h1;
  localparam S_HDR  = 3'h2;
  localparam S_TA   = 3'h3;
  localparam S_DATA = 3'h4;

  reg  [2:0]  state_q;
  reg  [5:0]  cnt_q;
  reg  [10:0] hdr_q;
  reg  [15:0] shift_q;
  reg         isRead_q;
  reg         isWrite_q;
  reg         mdcPrev_q;
  reg  [2:0]  page_q;
  reg  [15:0] cfg_q;
  reg         carrierCounted_q;
  reg         carrierCollided_q;
  reg         fcClear;
  reg         reClear;
  reg  [15:0] rdData;

  wire [CNT_W-1:0] fcCount;
  wire [CNT_W-1:0] reCount;
  wire             mdcRise = mdc & ~mdcPrev_q;
  wire             mdcFall = ~mdc & mdcPrev_q;
  wire [11:0]      hdrFull = {hdr_q, mdioIn};
  wire [1:0]       hdrOp   = hdrFull[11:10];
  wire [4:0]       hdrPhy  = hdrFull[9:5];
  wire [4:0]       hdrReg  = hdrFull[4:0];
  wire             hdrMine = (hdrPhy == phyAddr);

  // True when the address belongs to the page 0 bank held in this module.
  function isLocal;
    input [4:0] addr;
    input [2:0] page;
    begin
      isLocal = (page == `PSEC_PAGE_EXT0) &&
                (addr == `PSEC_ADDR_FALSE_CARRIER || addr == `PSEC_ADDR_RX_ERROR ||
                 addr == `PSEC_ADDR_CODING_CFG);
    end
  endfunction

  // True when the access leaves this module for another page or register.
  function isExternal;
    input [4:0] addr;
    input [2:0] page;
    reg         paged;
    begin
      paged = (addr >= `PSEC_ADDR_PAGED_LO) && (addr <= `PSEC_ADDR_PAGED_HI);
      if (addr == `PSEC_ADDR_PAGE_SEL || isLocal(addr, page)) begin
        isExternal = 1'b0;
      end else if (!paged) begin
        isExternal = 1'b1;
      end else begin
        case (page)
          `PSEC_PAGE_EXT0:     isExternal = 1'b1;
          `PSEC_PAGE_LINK_DIAG: isExternal = 1'b1;
          `PSEC_PAGE_TS_BASE:  isExternal = 1'b1;
          `PSEC_PAGE_TS_CFG_A: isExternal = 1'b1;
          `PSEC_PAGE_TS_CFG_B: isExternal = 1'b1;
          default:             isExternal = 1'b0;
        endcase
      end
    end
  endfunction

  assign register_page_selector           = page_q;
  assign rxClkFreeRun      = cfg_q[`PSEC_CFG_FREE_CLK_BIT];
  assign trueQuietEn       = cfg_q[`PSEC_CFG_TRUE_QUIET_BIT];
  assign signalDetectForce = cfg_q[`PSEC_CFG_SD_FORCE_BIT];

  // Read data mux; reserved pages and reserved bits return zero.
  always @* begin
    rdData = 16'h0000;
    if (hdrReg == `PSEC_ADDR_PAGE_SEL) begin
      rdData = {13'h0000, page_q};
    end else if (isLocal(hdrReg, page_q)) begin
      case (hdrReg)
        `PSEC_ADDR_FALSE_CARRIER: rdData = {{(16-CNT_W){1'b0}}, fcCount};
        `PSEC_ADDR_RX_ERROR:      rdData = {{(16-CNT_W){1'b0}}, reCount};
        default:                  rdData = cfg_q & `PSEC_CFG_WR_MASK;
      endcase
    end else if (isExternal(hdrReg, page_q)) begin
      rdData = extRdData;
    end
  end

  // Frame decoder. Bits are sampled on mdc rising edges.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= S_PRE;
      cnt_q     <= 6'h00;
      hdr_q     <= 11'h000;
      shift_q   <= 16'h0000;
      isRead_q  <= 1'b0;
      isWrite_q <= 1'b0;
      mdcPrev_q <= 1'b0;
      fcClear   <= 1'b0;
      reClear   <= 1'b0;
      extAddr   <= 5'h00;
      extRdEn   <= 1'b0;
      extWrEn   <= 1'b0;
      extWrData <= 16'h0000;
      page_q    <= `PSEC_PAGE_RESET;
      cfg_q     <= `PSEC_CFG_RESET;
      mdioOut   <= 1'b0;
      mdioOe    <= 1'b0;
    end else if (ce) begin
      mdcPrev_q <= mdc;
      fcClear   <= 1'b0;
      reClear   <= 1'b0;
      extRdEn   <= 1'b0;
      extWrEn   <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          S_PRE: begin
            if (mdioIn) begin
              if (cnt_q != `PSEC_PRE_ONES) begin
                cnt_q <= cnt_q + 6'h01;
              end
            end else if (cnt_q == `PSEC_PRE_ONES) begin
              state_q <= S_ST;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          S_ST: begin
            cnt_q   <= 6'h00;
            state_q <= mdioIn ? S_HDR : S_PRE;
          end
          S_HDR: begin
            hdr_q <= hdrFull[10:0];
            if (cnt_q == 6'h0B) begin
              cnt_q     <= 6'h00;
              state_q   <= S_TA;
              isRead_q  <= hdrMine && (hdrOp == `PSEC_OP_READ);
              isWrite_q <= hdrMine && (hdrOp == `PSEC_OP_WRITE);
              extAddr   <= hdrReg;
              if (hdrMine && hdrOp == `PSEC_OP_READ) begin
                shift_q <= rdData;
                extRdEn <= isExternal(hdrReg, page_q);
                if (isLocal(hdrReg, page_q)) begin
                  fcClear <= (hdrReg == `PSEC_ADDR_FALSE_CARRIER);
                  reClear <= (hdrReg == `PSEC_ADDR_RX_ERROR);
                end
              end
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          S_TA: begin
            if (cnt_q == 6'h01) begin
              cnt_q   <= 6'h00;
              state_q <= S_DATA;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          S_DATA: begin
            if (isWrite_q) begin
              shift_q <= {shift_q[14:0], mdioIn};
            end
            if (cnt_q == 6'h0F) begin
              cnt_q   <= 6'h00;
              state_q <= S_PRE;
              if (isWrite_q) begin
                if (extAddr == `PSEC_ADDR_PAGE_SEL) begin
                  page_q <= {shift_q[1:0], mdioIn};
                end else if (extAddr == `PSEC_ADDR_CODING_CFG &&
                             isLocal(extAddr, page_q)) begin
                  // Bits 15:12 are stored as written; the master keeps them zero.
                  cfg_q <= {shift_q[14:0], mdioIn} & `PSEC_CFG_WR_MASK;
                end else if (isExternal(extAddr, page_q)) begin
                  extWrEn   <= 1'b1;
                  extWrData <= {shift_q[14:0], mdioIn};
                end
              end
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          default: begin
            state_q <= S_PRE;
            cnt_q   <= 6'h00;
          end
        endcase
      end
      // A forwarded read takes its word one clk after the header, once extAddr stands.
      if (extRdEn) begin
        shift_q <= extRdData;
      end
      // Read data is launched on falling edges so it is stable at the master's rising edge.
      if (mdcFall) begin
        if (state_q == S_DATA && isRead_q) begin
          mdioOe  <= 1'b1;
          mdioOut <= shift_q[15];
          shift_q <= {shift_q[14:0], 1'b0};
        end else if (state_q == S_TA && isRead_q && cnt_q == 6'h01) begin
          mdioOe  <= 1'b1;
          mdioOut <= 1'b0;
        end else begin
          mdioOe  <= 1'b0;
          mdioOut <= 1'b0;
        end
      end
    end
  end

  // Receive error qualification: one count per carrier event, none from its first collision on.
  wire collidedNow = collision | carrierCollided_q;
  wire reIncr      = carrierValid && invalidSymbol && !carrierCounted_q && !collidedNow;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      carrierCounted_q  <= 1'b0;
      carrierCollided_q <= 1'b0;
    end else if (ce) begin
      if (!carrierValid) begin
        carrierCounted_q  <= 1'b0;
        carrierCollided_q <= 1'b0;
      end else begin
        if (reIncr) begin
          carrierCounted_q <= 1'b1;
        end
        if (collision) begin
          carrierCollided_q <= 1'b1;
        end
      end
    end
  end

  psec_sat_counter #(
    .WIDTH (CNT_W)
  ) uFalseCarrier (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .incr  (falseCarrierEvent),
    .clear (fcClear),
    .count (fcCount)
  );

  psec_sat_counter #(
    .WIDTH (CNT_W)
  ) uRxError (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .incr  (reIncr),
    .clear (reClear),
    .count (reCount)
  );

  psec_link_monitor #(
    .CNT_W     (TO_W),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) uLink (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .syncSeen         (syncSeen),
    .signalLevelValid (signalLevelValid),
    .sdForce          (cfg_q[`PSEC_CFG_SD_FORCE_BIT]),
    .sdAlgorithm      (cfg_q[`PSEC_CFG_SD_ALG_BIT]),
    .timeoutExtend    (cfg_q[`PSEC_CFG_DESC_EXT_BIT]),
    .descLocked       (descLocked),
    .linkUp           (linkUp)
  );
endmodule
`default_nettype wire

// File: core/psec_defs.vh
// Purpose: Shared constants for the page selector, event tallies and coding sublayer config.
// Assumes: Management register addresses are five bits wide, data sixteen bits.
// Notes:   Included by bare name; definitions only.
`ifndef PSEC_DEFS_VH
`define PSEC_DEFS_VH

`define PSEC_ADDR_PAGE_SEL      5'h13
`define PSEC_ADDR_FALSE_CARRIER 5'h14
`define PSEC_ADDR_RX_ERROR      5'h15
`define PSEC_ADDR_CODING_CFG    5'h16
`define PSEC_ADDR_PAGED_LO      5'h14
`define PSEC_ADDR_PAGED_HI      5'h1F

`define PSEC_PAGE_EXT0          3'h0
`define PSEC_PAGE_RSVD1         3'h1
`define PSEC_PAGE_LINK_DIAG     3'h2
`define PSEC_PAGE_RSVD3         3'h3
`define PSEC_PAGE_TS_BASE       3'h4
`define PSEC_PAGE_TS_CFG_A      3'h5
`define PSEC_PAGE_TS_CFG_B      3'h6
`define PSEC_PAGE_RESET         3'h0

`define PSEC_CFG_FREE_CLK_BIT   11
`define PSEC_CFG_TRUE_QUIET_BIT 10
`define PSEC_CFG_SD_FORCE_BIT   9
`define PSEC_CFG_SD_ALG_BIT     8
`define PSEC_CFG_DESC_EXT_BIT   7
`define PSEC_CFG_RESET          16'h0100
`define PSEC_CFG_WR_MASK        16'hFF80

`define PSEC_PRE_ONES           6'h20
`define PSEC_OP_WRITE           2'h1
`define PSEC_OP_READ            2'h2

`define PSEC_CLK_PERIOD_NS      10
`define PSEC_DESC_TO_SHORT_NS   722000
`define PSEC_DESC_TO_LONG_NS    2000000

`endif

// File: core/psec_sat_counter.v
// Purpose: Saturating event tally with clear.
// Assumes: incr and clear are one-cycle pulses in the clk domain.
// Notes:   An event in the clearing cycle survives as a count of one.
`timescale 1ns/100ps
`default_nettype none
module psec_sat_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             incr,
  input  wire             clear,
  output reg  [WIDTH-1:0] count
);
  wire atMax = &count;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (clear) begin
        count <= incr ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
      end else if (incr && !atMax) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// File: core/psec_link_monitor.v
// Purpose: Descrambler lock timeout and link status qualification.
// Assumes: syncSeen pulses whenever the descrambler recognises a valid symbol.
// Notes:   Timeout counts are parameters so a bench can shorten them.
`timescale 1ns/100ps
`default_nettype none
module psec_link_monitor #(
  parameter CNT_W     = 18,
  parameter SHORT_CYC = 72200,
  parameter LONG_CYC  = 200000
) (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire syncSeen,
  input  wire signalLevelValid,
  input  wire sdForce,
  input  wire sdAlgorithm,
  input  wire timeoutExtend,
  output reg  descLocked,
  output reg  linkUp
);
  reg  [CNT_W-1:0] idle_q;
  wire [CNT_W-1:0] limit = timeoutExtend ? LONG_CYC[CNT_W-1:0] : SHORT_CYC[CNT_W-1:0];
  wire             levelOk = signalLevelValid | sdForce;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_q     <= {CNT_W{1'b0}};
      descLocked <= 1'b0;
    end else if (ce) begin
      if (syncSeen) begin
        idle_q     <= {CNT_W{1'b0}};
        descLocked <= 1'b1;
      end else if (descLocked) begin
        if (idle_q >= limit - {{(CNT_W-1){1'b0}}, 1'b1}) begin
          descLocked <= 1'b0;
          idle_q     <= {CNT_W{1'b0}};
        end else begin
          idle_q <= idle_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      linkUp <= 1'b0;
    end else if (ce) begin
      if (!levelOk) begin
        linkUp <= 1'b0;
      end else if (!linkUp) begin
        linkUp <= descLocked;
      end else if (!descLocked && !sdAlgorithm) begin
        linkUp <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/psec_regs_checker.sv
// Purpose: Port assertions for the page select and tally bank.
// Assumes: Bound to psec_regs; mdc period of 8 clk or more.
// Notes:   Tally values are not on ports, so the bench reads them.
`timescale 1ns/100ps
`default_nettype none
module psec_regs_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       mdc,
  input wire logic       mdioOut,
  input wire logic       mdioOe,
  input wire logic       signalLevelValid,
  input wire logic       signalDetectForce,
  input wire logic       rxClkFreeRun,
  input wire logic       trueQuietEn,
  input wire logic       descLocked,
  input wire logic       linkUp,
  input wire logic [2:0] register_page_selector,
  input wire logic [4:0] extAddr,
  input wire logic       extRdEn,
  input wire logic       extWrEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire lvl = signalLevelValid | signalDetectForce;
  a_link_drops: assert property (ce && !lvl |=> !linkUp)
    else $error("link held without signal level");
  a_link_rises: assert property (ce && lvl && descLocked |=> linkUp)
    else $error("link not raised");
  a_link_cause: assert property ($rose(linkUp) |-> $past(lvl) && $past(descLocked))
    else $error("link raised without cause");
  // Outputs may only move just after an mdc fall, never deep in a high phase.
  a_out_holds: assert property (
    mdc && $past(mdc) && $past(mdc, 2) |-> $stable(mdioOut) && $stable(mdioOe))
    else $error("read data moved while mdc high");
  a_cfg_by_write: assert property (
    $changed({register_page_selector, rxClkFreeRun, trueQuietEn, signalDetectForce}) |-> $past(mdc))
    else $error("config changed outside a write");
  a_ce_freeze: assert property (
    !ce |=> $stable(linkUp) && $stable(descLocked) && $stable(register_page_selector))
    else $error("state moved with ce low");
  a_rd_pulse: assert property (extRdEn |=> !extRdEn)
    else $error("forwarded read longer than a cycle");
  a_ext_paged: assert property (
    (extRdEn || extWrEn) && extAddr >= 5'h14 && extAddr <= 5'h16
    |-> register_page_selector inside {3'h2, 3'h4, 3'h5, 3'h6})
    else $error("bank address forwarded on wrong page");
  c_link: cover property ($rose(linkUp));
  c_read: cover property ($rose(mdioOe));
  c_ext_wr: cover property (extWrEn);
endmodule
bind psec_regs psec_regs_checker u_psec_regs_checker (.clk(clk), .rst(rst), .ce(ce),
  .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .signalLevelValid(signalLevelValid),
  .signalDetectForce(signalDetectForce), .rxClkFreeRun(rxClkFreeRun),
  .trueQuietEn(trueQuietEn), .descLocked(descLocked), .linkUp(linkUp), .register_page_selector(register_page_selector),
  .extAddr(extAddr), .extRdEn(extRdEn), .extWrEn(extWrEn));
`default_nettype wire

// File: tb/psec_mgmt_master.sv
// Purpose: Station management master driving mdc and the mdio wire.
// Assumes: mdc period of 8 clk; mdc stands low between frames.
// Notes:   A released line reads high, as the wire carries a pull-up.
`timescale 1ns/100ps
`default_nettype none
module psec_mgmt_master (
  input  wire logic clk,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output var  logic mdc,
  output wire logic mdioLine
);
  logic drv;
  logic en;
  assign mdioLine = mdioOe ? mdioOut : (en ? drv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    en = 1'b0;
  end
  task automatic bitx(input logic b, input logic e, output logic s);
    drv = b;
    en = e;
    repeat (4) @(negedge clk);
    mdc = 1'b1;
    repeat (4) @(negedge clk);
    s = mdioLine;
    mdc = 1'b0;
  endtask
  task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, wr ? 2'b01 : 2'b10, phy, ra};
    for (int i = 0; i < 32; i++) bitx(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bitx(hdr[i], 1'b1, s);
    bitx(1'b1, wr, s);
    bitx(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bitx(wd[i], wr, s);
      rd[i] = s;
    end
    en = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/test_phy_page_select_error_counters.sv
// Purpose: Self-checking bench for the page select and tally bank.
// Assumes: Lock timeouts shortened to 20 and 50 cycles.
// Notes:   External page registers answer a value built from the address.
`timescale 1ns/100ps
`default_nettype none
module test_phy_page_select_error_counters;
  localparam logic [4:0] PHY = 5'h01;
  logic clk, rst, ce, mdc, mdioIn, mdioOut, mdioOe, falseCarrierEvent, carrierValid;
  logic invalidSymbol, collision, syncSeen, signalLevelValid, rxClkFreeRun, trueQuietEn;
  logic signalDetectForce, descLocked, linkUp, extRdEn, extWrEn;
  logic [2:0]  register_page_selector;
  logic [4:0]  phyAddr, extAddr;
  logic [15:0] extWrData, extRdData, rd, d;
  int          miscompares, check_count, cyc, wrSeen, n;
  assign extRdData = {8'hC3, 3'h0, extAddr};
  psec_regs #(.SHORT_CYC(20), .LONG_CYC(50)) u_psec_regs (.clk(clk), .rst(rst), .ce(ce),
    .phyAddr(phyAddr), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .falseCarrierEvent(falseCarrierEvent), .carrierValid(carrierValid),
    .invalidSymbol(invalidSymbol), .collision(collision), .syncSeen(syncSeen),
    .signalLevelValid(signalLevelValid), .rxClkFreeRun(rxClkFreeRun),
    .trueQuietEn(trueQuietEn), .signalDetectForce(signalDetectForce),
    .descLocked(descLocked), .linkUp(linkUp), .register_page_selector(register_page_selector), .extAddr(extAddr),
    .extRdEn(extRdEn), .extWrEn(extWrEn), .extWrData(extWrData), .extRdData(extRdData));
  psec_mgmt_master u_psec_mgmt_master (.clk(clk), .mdioOut(mdioOut), .mdioOe(mdioOe),
                                       .mdc(mdc), .mdioLine(mdioIn));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  function automatic logic [15:0] extExp(input logic [4:0] a);
    return {8'hC3, 3'h0, a};
  endfunction
  function automatic logic [15:0] pageExp(input int p, input logic [15:0] own, input logic [4:0] a);
    return (p == 0) ? own : (p == 1 || p == 3) ? 16'h0000 : extExp(a);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    u_psec_mgmt_master.frame(1'b1, PHY, a, v, rd);
  endtask
  task automatic rdr(input logic [4:0] a, input logic [15:0] e);
    u_psec_mgmt_master.frame(1'b0, PHY, a, 16'h0000, rd);
    chk(rd, e);
  endtask
  task automatic pulse(ref logic s, input int k);
    repeat (k) begin
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic carrier(input int k, input logic c);
    carrierValid = 1'b1;
    collision = c;
    @(negedge clk);
    pulse(invalidSymbol, k);
    carrierValid = 1'b0;
    collision = 1'b0;
    @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // The whole run needs about 25500 cycles; the ceiling leaves headroom.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (extWrEn === 1'b1) wrSeen <= wrSeen + 1;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    {rst, ce} = 2'b11;
    {falseCarrierEvent, carrierValid, invalidSymbol, collision} = 4'h0;
    {syncSeen, signalLevelValid} = 2'b00;
    phyAddr = PHY;
    {miscompares, check_count, cyc, wrSeen} = '0;
    n = $urandom(77);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    rdr(5'h13, 16'h0000);
    rdr(5'h16, 16'h0100);
    wr(5'h13, 16'hFFFF);
    rdr(5'h13, 16'h0007);
    rdr(5'h15, 16'h0000);
    for (int p = 0; p < 7; p++) begin
      wr(5'h13, 16'(p));
      rdr(5'h17, (p == 1 || p == 3) ? 16'h0000 : extExp(5'h17));
      rdr(5'h16, pageExp(p, 16'h0100, 5'h16));
    end
    $display("test pages done");
    d = 16'($urandom);
    wr(5'h14, d);
    chk(16'(wrSeen), 16'h0001);
    chk(extWrData, d);
    n = 1 + $urandom % 20;
    pulse(falseCarrierEvent, n);
    rdr(5'h14, extExp(5'h14));
    wr(5'h13, 16'h0000);
    rdr(5'h14, 16'(n));
    rdr(5'h14, 16'h0000);
    pulse(falseCarrierEvent, 300);
    wr(5'h14, 16'h0000);
    rdr(5'h14, 16'h00FF);
    $display("test false carrier done");
    carrier(1 + $urandom % 4, 1'b0);
    carrier(1 + $urandom % 4, 1'b0);
    carrier(2, 1'b1);
    rdr(5'h15, 16'h0002);
    repeat (260) carrier(1, 1'b0);
    rdr(5'h15, 16'h00FF);
    rdr(5'h15, 16'h0000);
    $display("test receive error done");
    repeat (3) begin
      d = {4'h0, 12'($urandom)};
      wr(5'h16, d);
      rdr(5'h16, d & 16'hFF80);
      chk({13'h0, rxClkFreeRun, trueQuietEn, signalDetectForce}, {13'h0, d[11:9]});
    end
    $display("test config done");
    // Force bit with signal level absent must still carry link.
    wr(5'h16, 16'h0300);
    pulse(syncSeen, 1);
    repeat (2) @(negedge clk);
    chk({15'h0, linkUp}, 16'h0001);
    wr(5'h16, 16'h0100);
    signalLevelValid = 1'b1;
    pulse(syncSeen, 1);
    repeat (2) @(negedge clk);
    ce = 1'b0;
    repeat (30) @(negedge clk);
    ce = 1'b1;
    chk({14'h0, descLocked, linkUp}, 16'h0003);
    repeat (30) @(negedge clk);
    chk({14'h0, descLocked, linkUp}, 16'h0001);
    signalLevelValid = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, linkUp}, 16'h0000);
    signalLevelValid = 1'b1;
    wr(5'h16, 16'h0000);
    pulse(syncSeen, 1);
    repeat (2) @(negedge clk);
    chk({15'h0, linkUp}, 16'h0001);
    repeat (30) @(negedge clk);
    chk({14'h0, descLocked, linkUp}, 16'h0000);
    wr(5'h16, 16'h0180);
    pulse(syncSeen, 1);
    repeat (30) @(negedge clk);
    chk({15'h0, descLocked}, 16'h0001);
    repeat (30) @(negedge clk);
    chk({15'h0, descLocked}, 16'h0000);
    $display("test link done");
    give_verdict();
  end
endmodule
`default_nettype wire
